// ===== hw/bam_area_output_mapper.sv
// Beam area evaluation with hysteresis and OR-mapped switching output behind an APB slave.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module bam_area_output_mapper
    import bam_pkg::*;
#(
    parameter int NUM_AREAS = 32,
    parameter int NUM_BEAMS = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_BEAMS-1:0] beamBlocked,
    input wire logic measDone,
    output logic pinOut,
    output logic pinOe,
    output logic [NUM_AREAS-1:0] areaState,
    output logic evalDone
);
    localparam int AW = $clog2(NUM_AREAS);
    localparam int MW = AW + 2;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (NUM_AREAS < 2 || NUM_AREAS > 32) begin : g_bad_areas
        $error("NUM_AREAS must lie between 2 and 32.");
    end
    if (NUM_BEAMS < 1 || NUM_BEAMS > 65531) begin : g_bad_beams
        $error("NUM_BEAMS must lie between 1 and 65531.");
    end

    typedef struct packed {
        bam_state_e st;
        logic [AW-1:0] area;
        logic [31:0] ctrlW;
        logic [31:0] beamsW;
        logic [NUM_BEAMS-1:0] beams;
        logic [15:0] firstBlk;
        logic [15:0] lastBlk;
        logic [NUM_AREAS-1:0] areaSt;
        logic [31:0] pinCfg;
        logic [NUM_AREAS-1:0] mask;
        logic pinOut;
        logic pinOe;
        logic evalDone;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bam_regs_s;

    bam_regs_s r_reg;
    bam_regs_s r_next;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Counts active beams between lo and hi, numbered from 1.
    function automatic logic [15:0] countActive(input logic [NUM_BEAMS-1:0] blk, input logic dark,
                                                input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] n;
        logic [15:0] num;
        n = '0;
        for (int b = 0; b < NUM_BEAMS; b++) begin
            num = 16'(b + 1);
            if (num >= lo && num <= hi && blk[b] == dark) begin
                n = n + 16'h0001;
            end
        end
        return n;
    endfunction : countActive

    // Number of the first blocked beam, zero when none is blocked.
    function automatic logic [15:0] firstBlocked(input logic [NUM_BEAMS-1:0] blk);
        logic [15:0] n;
        n = '0;
        for (int b = NUM_BEAMS - 1; b >= 0; b--) begin
            if (blk[b]) begin
                n = 16'(b + 1);
            end
        end
        return n;
    endfunction : firstBlocked

    // Number of the last blocked beam, zero when none is blocked.
    function automatic logic [15:0] lastBlocked(input logic [NUM_BEAMS-1:0] blk);
        logic [15:0] n;
        n = '0;
        for (int b = 0; b < NUM_BEAMS; b++) begin
            if (blk[b]) begin
                n = 16'(b + 1);
            end
        end
        return n;
    endfunction : lastBlocked

    // Merges write data into an old word under the byte strobes.
    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                v[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return v;
    endfunction : mergeStrb

    // ****************************************************************
    // Configuration memory
    // ****************************************************************
    logic [3:0] memWe;
    logic [MW-1:0] evalAddr;
    logic [MW-1:0] busAddr;
    logic [31:0] rdA;
    logic [31:0] rdB;
    logic inMem;
    logic busDone;
    logic [1:0] evalWord;

    // Area memory window and the completing edge of a transfer.
    assign inMem = (paddr >= BAM_AREA_BASE_OFF)
                   && (paddr < BAM_AREA_BASE_OFF + 12'(NUM_AREAS * BAM_AREA_STRIDE));
    assign busDone = psel && penable && r_reg.pready;
    assign busAddr = paddr[MW+1:2];
    assign memWe = (busDone && pwrite && inMem && paddr[1:0] == 2'h0) ? pstrb : 4'h0;

    // Each read state addresses its own word; the registered memory hands it to the following state.
    always_comb begin
        case (r_reg.st)
            BAM_RD_BEAMS: evalWord = BAM_AW_BEAMS;
            BAM_RD_THRESH: evalWord = BAM_AW_THRESH;
            default: evalWord = BAM_AW_CTRL;
        endcase
    end
    assign evalAddr = {r_reg.area, evalWord};

    bam_area_mem #(
        .AW(MW)
    ) u_mem (
        .clk(clk),
        .wrEn(memWe),
        .wrAddr(busAddr),
        .wrData(pwdata),
        .rdAddrA(evalAddr),
        .rdDataA(rdA),
        .rdAddrB(busAddr),
        .rdDataB(rdB)
    );

    // ****************************************************************
    // Evaluation and register bus
    // ****************************************************************
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] cnt;
    logic [15:0] onTh;
    logic [15:0] offTh;
    logic cur;
    logic newSt;
    logic [NUM_AREAS-1:0] finalSt;
    logic anySel;
    logic [31:0] rdVal;
    logic badAddr;

    // Bounds, count and hysteresis of the area being computed.
    always_comb begin
        lo = r_reg.beamsW[BAM_START_LSB +: 16];
        hi = r_reg.beamsW[BAM_END_LSB +: 16];
        if (lo == BAM_DYN_FIRST) begin
            lo = r_reg.firstBlk;
        end
        if (hi == BAM_DYN_LAST) begin
            hi = r_reg.lastBlk;
        end
        cnt = countActive(r_reg.beams, r_reg.ctrlW[BAM_LOGIC_BIT], lo, hi);
        onTh = rdA[BAM_ON_LSB +: 16];
        offTh = rdA[BAM_OFF_LSB +: 16];
        cur = r_reg.areaSt[r_reg.area];
        if (!r_reg.ctrlW[BAM_ENABLE_BIT]) begin
            newSt = 1'b0;
        end else if (cur) begin
            newSt = (cnt > offTh);
        end else begin
            newSt = (cnt >= onTh);
        end
        finalSt = r_reg.areaSt;
        finalSt[r_reg.area] = newSt;
        anySel = |(r_reg.areaSt & r_reg.mask);
    end

    // Register read decode; unmapped addresses answer with an error.
    always_comb begin
        rdVal = 32'h00000000;
        badAddr = 1'b0;
        if (paddr == BAM_PIN_CFG_OFF) begin
            rdVal = r_reg.pinCfg;
        end else if (paddr == BAM_AREA_MASK_OFF) begin
            rdVal = 32'(r_reg.mask);
        end else if (paddr == BAM_AREA_STATE_OFF) begin
            rdVal = 32'(r_reg.areaSt);
        end else if (paddr == BAM_BLOCKED_POS_OFF) begin
            rdVal = {r_reg.lastBlk, r_reg.firstBlk};
        end else if (inMem && paddr[1:0] == 2'h0) begin
            rdVal = rdB;
        end else begin
            badAddr = 1'b1;
        end
    end

    // Next state of the sequencer, the pin and the bus slave.
    always_comb begin
        r_next = r_reg;
        r_next.evalDone = 1'b0;
        case (r_reg.st)
            BAM_IDLE: begin
                if (measDone) begin
                    r_next.beams = beamBlocked;
                    r_next.firstBlk = firstBlocked(beamBlocked);
                    r_next.lastBlk = lastBlocked(beamBlocked);
                    r_next.area = '0;
                    r_next.st = BAM_RD_CTRL;
                end
            end
            BAM_RD_CTRL: begin
                r_next.st = BAM_RD_BEAMS;
            end
            BAM_RD_BEAMS: begin
                r_next.ctrlW = rdA;
                r_next.st = BAM_RD_THRESH;
            end
            BAM_RD_THRESH: begin
                r_next.beamsW = rdA;
                r_next.st = BAM_CALC;
            end
            BAM_CALC: begin
                r_next.areaSt = finalSt;
                if (r_reg.area == AW'(NUM_AREAS - 1)) begin
                    r_next.st = BAM_DONE;
                end else begin
                    r_next.area = r_reg.area + AW'(1);
                    r_next.st = BAM_RD_CTRL;
                end
            end
            BAM_DONE: begin
                r_next.pinOe = !r_reg.pinCfg[BAM_PIN_DIR_BIT];
                if (r_reg.pinCfg[BAM_PIN_FUNC_LSB +: 8] == BAM_FUNC_AREA_OUT) begin
                    r_next.pinOut = anySel ^ r_reg.pinCfg[BAM_PIN_POL_BIT];
                end else begin
                    r_next.pinOut = r_reg.pinCfg[BAM_PIN_POL_BIT];
                end
                r_next.evalDone = 1'b1;
                r_next.st = BAM_IDLE;
            end
            default: begin
                r_next.st = BAM_IDLE;
            end
        endcase
        // One wait state per transfer gives the memory time to answer.
        r_next.pready = psel && penable && !r_reg.pready;
        if (psel && penable && !r_reg.pready) begin
            r_next.prdata = pwrite ? 32'h00000000 : rdVal;
            r_next.pslverr = badAddr;
        end
        if (busDone && pwrite) begin
            if (paddr == BAM_PIN_CFG_OFF) begin
                r_next.pinCfg = mergeStrb(r_reg.pinCfg, pwdata, pstrb) & BAM_PIN_CFG_MASK;
            end else if (paddr == BAM_AREA_MASK_OFF) begin
                r_next.mask = NUM_AREAS'(mergeStrb(32'(r_reg.mask), pwdata, pstrb));
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (srst) begin
            r_reg <= '0;
            r_reg.st <= BAM_IDLE;
            r_reg.pinCfg <= BAM_PIN_CFG_RST;
            r_reg.mask <= NUM_AREAS'(BAM_AREA_MASK_RST);
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register.
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign pinOut = r_reg.pinOut;
    assign pinOe = r_reg.pinOe;
    assign areaState = r_reg.areaSt;
    assign evalDone = r_reg.evalDone;
endmodule : bam_area_output_mapper
`default_nettype wire

// ===== inc/bam_pkg.sv
// Constants, field layouts and state encoding of the beam area output mapper.
//
// Behaviour
// - Area enable bit joins area to evaluation.
// - Logic bit: 0 counts free, 1 counts blocked.
// - Area spans start to end beam, from 1.
// - On at on-count, off at off-count: hysteresis.
// - Light, 32 on 31 off: high when all free.
// - Dark, 32/31, inverted pin: low when all blocked.
// - Dark, 1/0, normal pin: high if any blocked.
// - Light, 1/0: low only when all blocked.
// - Direction field 0 makes pin an output.
// - Polarity field 1 inverts the output level.
// - Function field 1 selects area state output.
// - Pin follows OR of masked area states.
// - Start 65534 and end 65532 track blocked beams.
package bam_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] BAM_PIN_CFG_OFF = 12'h000;
    localparam logic [11:0] BAM_AREA_MASK_OFF = 12'h004;
    localparam logic [11:0] BAM_AREA_STATE_OFF = 12'h008;
    localparam logic [11:0] BAM_BLOCKED_POS_OFF = 12'h00C;
    localparam logic [11:0] BAM_AREA_BASE_OFF = 12'h200;
    localparam int BAM_AREA_STRIDE = 16;

    // ****************************************************************
    // Pin settings fields and reset values
    // ****************************************************************
    localparam int BAM_PIN_DIR_BIT = 24;
    localparam int BAM_PIN_POL_BIT = 16;
    localparam int BAM_PIN_FUNC_LSB = 0;
    localparam logic [7:0] BAM_FUNC_AREA_OUT = 8'h01;
    localparam logic [31:0] BAM_PIN_CFG_MASK = 32'h010100FF;
    localparam logic [31:0] BAM_PIN_CFG_RST = 32'h00000000;
    localparam logic [31:0] BAM_AREA_MASK_RST = 32'h00000000;

    // ****************************************************************
    // Area configuration words and fields
    // ****************************************************************
    localparam logic [1:0] BAM_AW_CTRL = 2'h0;
    localparam logic [1:0] BAM_AW_BEAMS = 2'h1;
    localparam logic [1:0] BAM_AW_THRESH = 2'h2;
    localparam int BAM_ENABLE_BIT = 8;
    localparam int BAM_LOGIC_BIT = 0;
    localparam int BAM_START_LSB = 16;
    localparam int BAM_END_LSB = 0;
    localparam int BAM_ON_LSB = 16;
    localparam int BAM_OFF_LSB = 0;
    localparam logic [15:0] BAM_DYN_FIRST = 16'hFFFE;
    localparam logic [15:0] BAM_DYN_LAST = 16'hFFFC;

    // ****************************************************************
    // Evaluation sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        BAM_IDLE = 3'h0,
        BAM_RD_CTRL = 3'h1,
        BAM_RD_BEAMS = 3'h3,
        BAM_RD_THRESH = 3'h2,
        BAM_CALC = 3'h6,
        BAM_DONE = 3'h7
    } bam_state_e;

endpackage : bam_pkg

// ===== hw/bam_area_mem.sv
// Area configuration memory with one byte-lane write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module bam_area_mem #(
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic [3:0] wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic [AW-1:0] rdAddrA,
    output logic [31:0] rdDataA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [31:0] rdDataB
);
    typedef struct packed {
        logic [(2**AW)-1:0][31:0] words;
        logic [31:0] dataA;
        logic [31:0] dataB;
    } bam_mem_s;

    bam_mem_s mem_reg;
    bam_mem_s mem_next;

    // Byte lanes are written independently; both reads come out of a register.
    always_comb begin
        mem_next = mem_reg;
        for (int b = 0; b < 4; b++) begin
            if (wrEn[b]) begin
                mem_next.words[wrAddr][b*8 +: 8] = wrData[b*8 +: 8];
            end
        end
        mem_next.dataA = mem_reg.words[rdAddrA];
        mem_next.dataB = mem_reg.words[rdAddrB];
    end

    // Contents carry no reset; software configures every used area.
    always_ff @(posedge clk) begin
        mem_reg <= mem_next;
    end

    assign rdDataA = mem_reg.dataA;
    assign rdDataB = mem_reg.dataB;
endmodule : bam_area_mem
`default_nettype wire

// ===== verif/bam_area_output_mapper_chk.sv
// Port-level assertions of the beam area output mapper.
`timescale 1ns/1ps
`default_nettype none
module bam_area_output_mapper_chk #(
    parameter int NUM_AREAS = 32,
    parameter int NUM_BEAMS = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic measDone,
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic [NUM_AREAS-1:0] areaState,
    input wire logic evalDone
);
    localparam int EVL = 4 * NUM_AREAS + 2;
    localparam int EVH = EVL + 1;
    logic [31:0] cfgReg, maskReg;
    logic busyReg;
    wire logic take = measDone && (!busyReg || evalDone);
    wire logic wrOk = psel && penable && pready && pwrite;
    wire logic pinExp = cfgReg[16] ^ (cfgReg[7:0] == 8'h01 && |(areaState & maskReg[NUM_AREAS-1:0]));
    // Shadow the pin settings and mask as written, and track a running evaluation.
    always_ff @(posedge clk) begin
        if (srst) begin
            cfgReg <= 32'h00000000;
            maskReg <= 32'h00000000;
            busyReg <= 1'b0;
        end else begin
            if (wrOk && paddr == 12'h000) cfgReg <= pwdata & 32'h010100FF;
            if (wrOk && paddr == 12'h004) maskReg <= pwdata;
            busyReg <= take || (busyReg && !evalDone);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    ready_wait_a: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("access phase length wrong");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read data not zero");
    eval_time_a: assert property (take |-> ##[EVL:EVH] evalDone) else $error("evaluation late");
    eval_pulse_a: assert property (evalDone |=> !evalDone) else $error("evalDone held too long");
    pin_hold_a: assert property ($changed(pinOut) || $changed(pinOe) |-> evalDone)
        else $error("pin changed between evaluations");
    oe_dir_a: assert property (evalDone |-> pinOe == !cfgReg[24]) else $error("pinOe wrong");
    pin_map_a: assert property (evalDone |-> pinOut == pinExp) else $error("pinOut wrong");
    take_c: cover property (take);
    refuse_c: cover property (pready && pslverr);
    pin_on_c: cover property (evalDone && pinOut);
endmodule : bam_area_output_mapper_chk
bind bam_area_output_mapper bam_area_output_mapper_chk #(.NUM_AREAS(NUM_AREAS), .NUM_BEAMS(NUM_BEAMS)) u_chk (.clk,
    .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .measDone, .pinOut, .pinOe,
    .areaState, .evalDone);
`default_nettype wire

// ===== verif/bam_meas_model.sv
// Measurement front end model: presents beam states and ends each measurement.
`timescale 1ns/1ps
`default_nettype none
module bam_meas_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic go,
    input wire logic [31:0] pattern,
    output logic [31:0] beamBlocked,
    output logic measDone
);
    // Latch a measurement's beams and mark its end with a one-cycle pulse.
    always_ff @(posedge clk) begin
        if (srst) begin
            beamBlocked <= 32'h00000000;
            measDone <= 1'b0;
        end else begin
            measDone <= go;
            beamBlocked <= go ? pattern : beamBlocked;
        end
    end
endmodule : bam_meas_model
`default_nettype wire

// ===== verif/bam_area_output_mapper_tb_top.sv
// Self-checking bench of the beam area output mapper.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module bam_area_output_mapper_tb_top;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic pready, pslverr, measDone, pinOut, pinOe, evalDone, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, pattern = 32'h00000000, prdata, beamBlocked, rd;
    logic [1:0] areaState;
    int fails = 0, checked = 0, cyc = 0;
    bam_meas_model u_bam_meas_model (.clk, .srst, .go, .pattern, .beamBlocked, .measDone);
    bam_area_output_mapper #(.NUM_AREAS(2)) u_bam_area_output_mapper (.clk, .srst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .beamBlocked, .measDone, .pinOut, .pinOe, .areaState,
        .evalDone);
    // Clock of 50 ns period, and a cycle ceiling that cuts a hang short.
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report();
        $display("Checked %0d, failed %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One measurement through the front end model, then the pin is judged.
    task automatic meas(input logic [31:0] p, input logic e);
        @(posedge clk);
        pattern <= p;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (evalDone !== 1'b1);
        `CHK("pinOut", e, pinOut)
    endtask : meas
    task automatic pc(input logic [31:0] c, input logic [31:0] m);
        apb(1'b1, 12'h000, c);
        apb(1'b1, 12'h004, m);
    endtask : pc
    task automatic ar(input logic [31:0] c, input logic [31:0] b, input logic [31:0] t);
        apb(1'b1, 12'h200, c);
        apb(1'b1, 12'h204, b);
        apb(1'b1, 12'h208, t);
    endtask : ar
    task automatic lc(input logic dk, input logic [15:0] on, input logic [15:0] off, input logic pol, input logic [2:0] e);
        pc({15'h0000, pol, 16'h0001}, 32'h00000001);
        ar({23'h000000, 1'b1, 7'h00, dk}, 32'h00010020, {on, off});
        meas(32'h00000000, e[2]);
        meas(32'h00000001, e[1]);
        meas(32'hFFFFFFFF, e[0]);
    endtask : lc
    task automatic pp(input logic [31:0] c, input logic [31:0] m, input logic e, input logic oe);
        pc(c, m);
        meas(32'hFFFFFFFF, e);
        `CHK("pinOe", oe, pinOe)
    endtask : pp
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h00000000);
        `CHK("pin cfg reset", 32'h00000000, rd)
        apb(1'b1, 12'h000, 32'hFFFFFFFF);
        apb(1'b0, 12'h000, 32'h00000000);
        `CHK("pin cfg bits", 32'h010100FF, rd)
        apb(1'b0, 12'h100, 32'h00000000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, rd)
        apb(1'b1, 12'h210, 32'h00000000);
        $display("register test done");
    endtask : t_regs
    task automatic t_table();
        lc(1'b0, 16'h0020, 16'h001F, 1'b0, 3'b100);
        lc(1'b1, 16'h0020, 16'h001F, 1'b1, 3'b110);
        lc(1'b1, 16'h0001, 16'h0000, 1'b0, 3'b011);
        lc(1'b0, 16'h0001, 16'h0000, 1'b0, 3'b110);
        $display("logic table test done");
    endtask : t_table
    task automatic t_hyst();
        pc(32'h00000001, 32'h00000001);
        ar(32'h00000101, 32'h00010020, 32'h0014000A);
        meas(32'h00007FFF, 1'b0);
        meas(32'h01FFFFFF, 1'b1);
        meas(32'h00007FFF, 1'b1);
        apb(1'b0, 12'h008, 32'h00000000);
        `CHK("area states", 32'h00000001, rd)
        `CHK("area state port", 2'h1, areaState)
        meas(32'h000003FF, 1'b0);
        $display("hysteresis test done");
    endtask : t_hyst
    task automatic t_bounds();
        ar(32'h00000101, 32'h00050008, 32'h00010000);
        meas(32'h00000008, 1'b0);
        meas(32'h00000100, 1'b0);
        meas(32'h00000010, 1'b1);
        meas(32'h00000080, 1'b1);
        apb(1'b1, 12'h200, 32'h00000001);
        meas(32'h00000010, 1'b0);
        $display("bounds test done");
    endtask : t_bounds
    task automatic t_pins();
        ar(32'h00000101, 32'h00010020, 32'h00010000);
        pp(32'h00000001, 32'h00000001, 1'b1, 1'b1);
        pp(32'h00010001, 32'h00000001, 1'b0, 1'b1);
        pp(32'h00000001, 32'h00000002, 1'b0, 1'b1);
        pp(32'h00000001, 32'h00000003, 1'b1, 1'b1);
        pp(32'h00010000, 32'h00000001, 1'b1, 1'b1);
        pp(32'h01000001, 32'h00000001, 1'b1, 1'b0);
        $display("pin test done");
    endtask : t_pins
    task automatic t_dyn();
        pc(32'h00010001, 32'h00000001);
        ar(32'h00000100, 32'hFFFEFFFC, 32'h00010000);
        meas(32'h000003DC, 1'b0);
        apb(1'b0, 12'h00C, 32'h00000000);
        `CHK("blocked span", 32'h000A0003, rd)
        meas(32'h000003FC, 1'b1);
        $display("dynamic area test done");
    endtask : t_dyn
    // Reset for eight cycles, then run every scenario in turn.
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_table();
        t_hyst();
        t_bounds();
        t_pins();
        t_dyn();
        final_report();
    end
endmodule : bam_area_output_mapper_tb_top
`default_nettype wire
